// >>> logic/dp_diag_pkg.sv
// Purpose: Shared constants for the diagnostics link between a fieldbus slave and its master
// Assumes: One clock, synchronous active-high reset
// Notes: Frame is six standard bytes followed by six device-specific bytes
package dp_diag_pkg;
    // ****************************************
    // Frame layout
    // ****************************************
    localparam int STD_LEN = 6;
    localparam int DEV_LEN = 6;
    localparam int FRAME_LEN = STD_LEN + DEV_LEN;
    localparam logic [3:0] FRAME_LAST = 4'(FRAME_LEN - 1);
    localparam logic [3:0] B_SS1 = 4'h0;
    localparam logic [3:0] B_SS2 = 4'h1;
    localparam logic [3:0] B_SS3 = 4'h2;
    localparam logic [3:0] B_OWNER = 4'h3;
    localparam logic [3:0] B_VEND_LO = 4'h4;
    localparam logic [3:0] B_VEND_HI = 4'h5;
    localparam logic [3:0] B_DHDR = 4'h6;
    localparam logic [3:0] B_DTYPE = 4'h7;
    localparam logic [3:0] B_DSLOT = 4'h8;
    localparam logic [3:0] B_DSPEC = 4'h9;
    localparam logic [3:0] B_DDAT0 = 4'ha;
    localparam logic [3:0] B_DDAT1 = 4'hb;
    // ****************************************
    // Station status fields
    // ****************************************
    localparam int SS1_MASTER_LOCK = 7;
    localparam int SS1_PARAM_FAULT = 6;
    localparam int SS1_INVALID_RESP = 5;
    localparam int SS1_SVC_UNSUP = 4;
    localparam int SS1_EXT_DIAG = 3;
    localparam int SS1_CFG_FAULT = 2;
    localparam int SS1_NOT_READY = 1;
    localparam int SS1_NON_EXIST = 0;
    localparam int SS2_FROM_SLAVE = 2;
    localparam logic [7:0] SS2_VALUE = 8'h04;
    localparam logic [7:0] SS3_VALUE = 8'h00;
    localparam logic [7:0] OWNER_NONE = 8'hff;
    // ****************************************
    // Device-specific coding
    // ****************************************
    localparam logic [1:0] HDR_TAG = 2'h0;
    localparam logic [7:0] DEV_HDR = {HDR_TAG, 6'(DEV_LEN)};
    localparam int TYPE_BIT = 7;
    localparam logic TYPE_IRQ = 1'b0;
    localparam logic TYPE_STATUS = 1'b1;
    localparam logic [6:0] ALARM_DIAG = 7'h01;
    localparam logic [6:0] STATUS_INFO = 7'h01;
    localparam logic [1:0] SPEC_NONE = 2'h0;
    localparam logic [1:0] SPEC_APPEARS = 2'h1;
    // ****************************************
    // Controller registers
    // ****************************************
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_OWN = 5'h04;
    localparam logic [4:0] REG_STAT = 5'h08;
    localparam logic [4:0] REG_DIAG0 = 5'h0c;
    localparam logic [4:0] REG_DIAG1 = 5'h10;
    localparam logic [4:0] REG_DIAG2 = 5'h14;
    localparam int CTRL_V1 = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_UNSUP = 2;
    localparam logic CTRL_V1_RESET = 1'b1;
    localparam logic [7:0] OWN_RESET = 8'h01;
    localparam int TIMEOUT_CYC = 64;
endpackage

// >>> logic/dp_diag_if.sv
// Purpose: Link between the slave diagnostics framer and the master controller
// Assumes: Both ends on the same clock
// Notes: No back-pressure on the byte stream
`timescale 1ns/1ps
`default_nettype none
interface dp_diag_if;
    logic mode_v1;
    logic diag_req;
    logic diag_ack;
    logic notify;
    logic rx_valid;
    logic rx_last;
    logic [7:0] rx_data;
    modport slave (input mode_v1, input diag_req, input diag_ack,
        output notify, output rx_valid, output rx_last, output rx_data);
    modport master (output mode_v1, output diag_req, output diag_ack,
        input notify, input rx_valid, input rx_last, input rx_data);
endinterface
`default_nettype wire

// >>> logic/dp_master_diag_ctrl.sv
// Purpose: Master end, fetches and checks the slave diagnostics frame
// Assumes: Avalon-MM slave with one wait cycle per access
// Notes: Fetches on software start or while the slave signals a pending event
`timescale 1ns/1ps
`default_nettype none
module dp_master_diag_ctrl
    import dp_diag_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    dp_diag_if.master link,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [1:0] {M_IDLE, M_REQ, M_WAIT, M_ACK} mst_st_t;
    typedef struct packed {
        mst_st_t st;
        logic v1;
        logic unsup;
        logic [7:0] own;
        logic [FRAME_LEN-1:0][7:0] copy;
        logic [3:0] cnt;
        logic [15:0] tmr;
        logic done;
        logic tout;
        logic acked;
        logic acc;
        logic [31:0] rdata;
    } mst_state_t;

    mst_state_t s_q, s_d;
    logic start_w;
    logic plaus;

    assign avs_waitrequest = (avs_read | avs_write) & ~s_q.acc;
    assign avs_readdata = s_q.rdata;
    assign link.mode_v1 = s_q.v1;
    assign link.diag_req = (s_q.st == M_REQ);
    assign link.diag_ack = (s_q.st == M_ACK);
    assign start_w = s_q.acc & avs_write & (avs_address == REG_CTRL) & avs_writedata[CTRL_START];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        plaus = 1'b0;
        s_d.acc = (avs_read | avs_write) & ~s_q.acc;
        if (avs_read & ~s_q.acc) begin
            case (avs_address)
                REG_CTRL: s_d.rdata = {29'h0, s_q.unsup, 1'b0, s_q.v1};
                REG_OWN: s_d.rdata = {24'h0, s_q.own};
                REG_STAT: s_d.rdata = {27'h0, s_q.acked, s_q.tout, link.notify, s_q.done,
                    (s_q.st != M_IDLE)};
                REG_DIAG0: s_d.rdata = {s_q.copy[3], s_q.copy[2], s_q.copy[1], s_q.copy[0]};
                REG_DIAG1: s_d.rdata = {s_q.copy[7], s_q.copy[6], s_q.copy[5], s_q.copy[4]};
                REG_DIAG2: s_d.rdata = {s_q.copy[11], s_q.copy[10], s_q.copy[9], s_q.copy[8]};
                default: s_d.rdata = 32'h0;
            endcase
        end
        if (s_q.acc & avs_write) begin
            if (avs_address == REG_CTRL) begin
                s_d.v1 = avs_writedata[CTRL_V1];
                s_d.unsup = avs_writedata[CTRL_UNSUP];
            end
            if (avs_address == REG_OWN) begin
                s_d.own = avs_writedata[7:0];
            end
        end
        case (s_q.st)
            M_IDLE: begin
                if (start_w | link.notify) begin
                    s_d.st = M_REQ;
                    s_d.cnt = 4'h0;
                    s_d.tmr = 16'h0;
                    s_d.done = 1'b0;
                    s_d.tout = 1'b0;
                    s_d.acked = 1'b0;
                end
            end
            M_REQ: s_d.st = M_WAIT;
            M_WAIT: begin
                s_d.tmr = s_q.tmr + 16'h1;
                if (link.rx_valid) begin
                    s_d.copy[s_q.cnt] = link.rx_data;
                    s_d.cnt = s_q.cnt + 4'h1;
                    if (link.rx_last) begin
                        plaus = (s_q.cnt == FRAME_LAST) & s_d.copy[B_SS2][SS2_FROM_SLAVE]
                            & ~s_d.copy[B_SS1][SS1_NON_EXIST];
                        s_d.copy[B_SS1][SS1_INVALID_RESP] = ~plaus;
                        s_d.copy[B_SS1][SS1_MASTER_LOCK] = (s_d.copy[B_OWNER] != s_q.own)
                            & (s_d.copy[B_OWNER] != OWNER_NONE);
                        s_d.copy[B_SS1][SS1_SVC_UNSUP] = s_q.unsup;
                        s_d.done = 1'b1;
                        if (s_q.v1 & plaus & (s_d.copy[B_DTYPE][TYPE_BIT] == TYPE_IRQ)) begin
                            s_d.st = M_ACK;
                        end else begin
                            s_d.st = M_IDLE;
                        end
                    end
                end else if (s_q.tmr == 16'(TIMEOUT - 1)) begin
                    s_d.copy[B_SS1][SS1_NON_EXIST] = 1'b1;
                    s_d.copy[B_SS1][SS1_INVALID_RESP] = 1'b1;
                    s_d.tout = 1'b1;
                    s_d.done = 1'b1;
                    s_d.st = M_IDLE;
                end
            end
            M_ACK: begin
                s_d.acked = 1'b1;
                s_d.st = M_IDLE;
            end
            default: s_d.st = M_IDLE;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= M_IDLE;
            s_q.v1 <= CTRL_V1_RESET;
            s_q.own <= OWN_RESET;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// >>> logic/dp_slave_diag_framer.sv
// Purpose: Slave end, builds the twelve-byte diagnostics frame on request
// Assumes: Status inputs synchronous to clk
// Notes: A new event overwrites an older unsent one only while idle; during a frame its slot and data are not stored
`timescale 1ns/1ps
`default_nettype none
module dp_slave_diag_framer
    import dp_diag_pkg::*;
#(
    // Arbitrary identifier value
    parameter logic [15:0] VENDOR_ID = 16'h5a3c
) (
    input wire logic clk,
    input wire logic srst,
    dp_diag_if.slave link,
    input wire logic param_fault_set,
    input wire logic param_ok,
    input wire logic cfg_reject,
    input wire logic cfg_ok,
    input wire logic not_ready,
    input wire logic owner_valid,
    input wire logic [7:0] owner_addr,
    input wire logic event_valid,
    input wire logic [7:0] event_slot,
    input wire logic [31:0] event_data,
    input wire logic [31:0] status_data,
    output logic busy,
    output logic event_pending
);
    typedef enum logic [0:0] {S_IDLE, S_SEND} tx_st_t;
    typedef struct packed {
        tx_st_t st;
        logic [3:0] idx;
        logic pend;
        logic pfault;
        logic cfault;
        logic [4:0] seq;
        logic [7:0] slot;
        logic [31:0] edata;
        logic is_evt;
        logic v1;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_last;
    } dev_state_t;

    dev_state_t s_q, s_d;
    logic [7:0] fb;
    logic [7:0] ss1;
    logic [31:0] mdata;

    assign link.notify = s_q.pend;
    assign link.rx_valid = s_q.tx_valid;
    assign link.rx_last = s_q.tx_last;
    assign link.rx_data = s_q.tx_data;
    assign busy = (s_q.st == S_SEND);
    assign event_pending = s_q.pend;
    assign mdata = s_q.is_evt ? s_q.edata : status_data;

    // ****************************************
    // Frame byte select
    // ****************************************
    always_comb begin
        ss1 = 8'h0;
        ss1[SS1_PARAM_FAULT] = s_q.pfault;
        ss1[SS1_EXT_DIAG] = s_q.is_evt;
        ss1[SS1_CFG_FAULT] = s_q.cfault;
        ss1[SS1_NOT_READY] = not_ready;
        ss1[SS1_NON_EXIST] = 1'b0;
        fb = 8'h0;
        case (s_q.idx)
            B_SS1: fb = ss1;
            B_SS2: fb = SS2_VALUE;
            B_SS3: fb = SS3_VALUE;
            B_OWNER: fb = owner_valid ? owner_addr : OWNER_NONE;
            B_VEND_LO: fb = VENDOR_ID[7:0];
            B_VEND_HI: fb = VENDOR_ID[15:8];
            B_DHDR: fb = DEV_HDR;
            default: fb = 8'h0;
        endcase
        if (s_q.v1) begin
            case (s_q.idx)
                B_DTYPE: fb = s_q.is_evt ? {TYPE_IRQ, ALARM_DIAG} : {TYPE_STATUS, STATUS_INFO};
                B_DSLOT: fb = s_q.is_evt ? s_q.slot : 8'h0;
                B_DSPEC: fb = {s_q.seq, 1'b0, s_q.is_evt ? SPEC_APPEARS : SPEC_NONE};
                B_DDAT0: fb = mdata[7:0];
                B_DDAT1: fb = mdata[15:8];
                default: fb = fb;
            endcase
        end else begin
            case (s_q.idx)
                B_DTYPE: fb = s_q.is_evt ? s_q.slot : 8'h0;
                B_DSLOT: fb = mdata[7:0];
                B_DSPEC: fb = mdata[15:8];
                B_DDAT0: fb = mdata[23:16];
                B_DDAT1: fb = mdata[31:24];
                default: fb = fb;
            endcase
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.tx_valid = 1'b0;
        s_d.tx_last = 1'b0;
        if (param_ok) begin
            s_d.pfault = 1'b0;
        end
        if (param_fault_set) begin
            s_d.pfault = 1'b1;
        end
        if (cfg_ok) begin
            s_d.cfault = 1'b0;
        end
        if (cfg_reject) begin
            s_d.cfault = 1'b1;
        end
        case (s_q.st)
            S_IDLE: begin
                if (link.diag_req) begin
                    s_d.st = S_SEND;
                    s_d.idx = 4'h0;
                    s_d.is_evt = s_q.pend;
                    s_d.v1 = link.mode_v1;
                end
            end
            S_SEND: begin
                s_d.tx_data = fb;
                s_d.tx_valid = 1'b1;
                s_d.tx_last = (s_q.idx == FRAME_LAST);
                s_d.idx = s_q.idx + 4'h1;
                if (s_q.idx == FRAME_LAST) begin
                    s_d.st = S_IDLE;
                    if (~s_q.v1 & s_q.is_evt) begin
                        s_d.pend = 1'b0;
                    end
                end
            end
            default: s_d.st = S_IDLE;
        endcase
        if (link.diag_ack & s_q.v1) begin
            s_d.pend = 1'b0;
        end
        if (event_valid) begin
            s_d.pend = 1'b1;
            if (s_q.st == S_IDLE) begin
                s_d.slot = event_slot;
                s_d.edata = event_data;
            end
            s_d.seq = s_q.seq + 5'h01;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= S_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// >>> tb/dp_diag_chk.sv
// Purpose: Checker on the diagnostics link between both ends
// Assumes: One clock, srst synchronous active high
// Notes: Sees only the link signals
`timescale 1ns/1ps
`default_nettype none
module dp_diag_chk
    import dp_diag_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic mode_v1,
    input wire logic diag_req,
    input wire logic diag_ack,
    input wire logic notify,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic [7:0] rx_data
);
    // ****************************************
    // Byte index and type byte
    // ****************************************
    logic [3:0] idx_q;
    logic [7:0] typ_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            idx_q <= 4'h0;
            typ_q <= 8'h00;
        end else if (rx_valid) begin
            idx_q <= rx_last ? 4'h0 : idx_q + 4'h1;
            if (idx_q == B_DTYPE) begin
                typ_q <= rx_data;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_head;
        (rx_valid && !rx_last)[*8];
    endsequence
    sequence s_tail;
        (rx_valid && !rx_last)[*3] ##1 (rx_valid && rx_last);
    endsequence
    chk_frame_twelve_bytes: assert property (diag_req |-> ##2 s_head ##1 s_tail)
        else $error("frame length or timing wrong");
    chk_bit0_zero: assert property (diag_req |-> ##2 !rx_data[SS1_NON_EXIST])
        else $error("status 1 bit 0 not zero");
    chk_from_slave: assert property (diag_req |-> ##3 rx_data == SS2_VALUE)
        else $error("status 2 wrong");
    chk_status3_zero: assert property (diag_req |-> ##4 rx_data == SS3_VALUE)
        else $error("status 3 wrong");
    chk_dev_header: assert property (diag_req |-> ##8 rx_data == DEV_HDR)
        else $error("header byte wrong");
    chk_last_index: assert property (rx_last |-> rx_valid && idx_q == FRAME_LAST)
        else $error("last flag off byte 11");
    chk_v1_event_ack: assert property (rx_last && mode_v1 && !typ_q[TYPE_BIT] |=> diag_ack)
        else $error("interrupt not acked");
    chk_v1_status_quiet: assert property (rx_last && mode_v1 && typ_q[TYPE_BIT] |=> !diag_ack)
        else $error("status frame acked");
    chk_v0_no_ack: assert property (rx_last && !mode_v1 |=> !diag_ack [*3])
        else $error("alarm acked");
    chk_ack_clears: assert property (diag_ack |=> !notify)
        else $error("pending kept after ack");
endmodule
`default_nettype wire

// >>> tb/dp_slave_diag_framer_tb.sv
// Purpose: Bench for framer and master joined by the link
// Assumes: 20 MHz clock, srst held 16 cycles
// Notes: Second master faces a silent far end
`timescale 1ns/1ps
`default_nettype none
module dp_slave_diag_framer_tb;
    import dp_diag_pkg::*;
    localparam logic [15:0] VID = 16'h1234; // Arbitrary value
    logic clk, srst, pfs, pok, crj, cok, nrdy, ovl, evv, busy, evp;
    logic [7:0] oad, evs;
    logic [31:0] evd, st_data, q;
    logic [4:0] av_a [2];
    logic av_r [2], av_w [2], av_wt [2];
    logic [31:0] av_wd [2], av_rd [2];
    logic [7:0] fr [12];
    int idx, nfr, nbusy, miscompares, check_count;
    dp_diag_if lk();
    dp_diag_if lk2();
    assign lk2.notify = 1'b0;
    assign lk2.rx_valid = 1'b0;
    assign lk2.rx_last = 1'b0;
    assign lk2.rx_data = 8'h00;
    dp_slave_diag_framer #(.VENDOR_ID(VID)) dp_slave_diag_framer_inst (.clk(clk), .srst(srst),
        .link(lk.slave), .param_fault_set(pfs), .param_ok(pok), .cfg_reject(crj), .cfg_ok(cok),
        .not_ready(nrdy), .owner_valid(ovl), .owner_addr(oad), .event_valid(evv),
        .event_slot(evs), .event_data(evd), .status_data(st_data), .busy(busy),
        .event_pending(evp));
    dp_master_diag_ctrl #(.TIMEOUT(16)) dp_master_diag_ctrl_inst (.clk(clk), .srst(srst),
        .link(lk.master), .avs_address(av_a[0]), .avs_read(av_r[0]), .avs_write(av_w[0]),
        .avs_writedata(av_wd[0]), .avs_readdata(av_rd[0]), .avs_waitrequest(av_wt[0]));
    dp_master_diag_ctrl #(.TIMEOUT(16)) dp_master_diag_ctrl_inst2 (.clk(clk), .srst(srst),
        .link(lk2.master), .avs_address(av_a[1]), .avs_read(av_r[1]), .avs_write(av_w[1]),
        .avs_writedata(av_wd[1]), .avs_readdata(av_rd[1]), .avs_waitrequest(av_wt[1]));
    dp_diag_chk dp_diag_chk_inst (.clk(clk), .srst(srst), .mode_v1(lk.mode_v1),
        .diag_req(lk.diag_req), .diag_ack(lk.diag_ack), .notify(lk.notify),
        .rx_valid(lk.rx_valid), .rx_last(lk.rx_last), .rx_data(lk.rx_data));
    // ****************************************
    // Clock, frame capture, helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (lk.rx_valid === 1'b1) begin
            fr[idx] <= lk.rx_data;
            idx <= (lk.rx_last === 1'b1) ? 0 : idx + 1;
            nfr <= nfr + ((lk.rx_last === 1'b1) ? 1 : 0);
        end
        if (busy === 1'b1) begin
            nbusy <= nbusy + 1;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input int s, input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        av_a[s] <= a;
        av_wd[s] <= d;
        av_w[s] <= w;
        av_r[s] <= !w;
        forever begin
            @(posedge clk);
            if (av_wt[s] === 1'b0) begin
                q = av_rd[s];
                break;
            end
        end
        av_w[s] <= 1'b0;
        av_r[s] <= 1'b0;
    endtask
    task automatic wait_frame();
        int n0;
        int b0;
        n0 = nfr;
        b0 = nbusy;
        for (int i = 0; i < 100 && nfr == n0; i++) begin
            @(posedge clk);
        end
        repeat (6) @(posedge clk);
        chk("frames", 32'(n0 + 1), 32'(nfr));
        chk("busy_len", 32'(FRAME_LEN), 32'(nbusy - b0));
    endtask
    // Bits: 4 param fault, 3 param ok, 2 cfg reject, 1 cfg ok, 0 event
    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        {pfs, pok, crj, cok, evv} <= m;
        @(posedge clk);
        {pfs, pok, crj, cok, evv} <= 5'h00;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_status_v1();
        st_data <= 32'h0000beef;
        for (int i = 0; i < 2; i++) begin
            nrdy <= (i == 0);
            bus(0, 1'b1, REG_CTRL, 32'h3);
            wait_frame();
            chk("std0", {24'hff0004, 6'h0, i == 0, 1'b0}, {fr[3], fr[2], fr[1], fr[0]});
            chk("std1", {8'h81, 8'h06, VID}, {fr[7], fr[6], fr[5], fr[4]});
            chk("sdat", 32'hbeef, {16'h0, fr[11], fr[10]});
        end
        bus(0, 1'b0, REG_DIAG0, 32'h0);
        chk("diag0", 32'hff000400, q);
        bus(0, 1'b0, REG_STAT, 32'h0);
        chk("stat", 32'h02, q & 32'h1e);
        bus(0, 1'b0, 5'h1c, 32'h0);
        chk("unmap", 32'h0, q);
    endtask
    task automatic t_event_v1();
        ovl <= 1'b1;
        oad <= 8'h22;
        pulse(5'h10);
        pulse(5'h04);
        bus(0, 1'b1, REG_CTRL, 32'h5);
        evs <= 8'h03;
        evd <= 32'h44332211;
        pulse(5'h01);
        wait_frame();
        chk("ss1", 32'h4c, {24'h0, fr[0]});
        chk("v1dev", 32'h090301, {8'h0, fr[9], fr[8], fr[7]});
        chk("v1dat", 32'h2211, {16'h0, fr[11], fr[10]});
        chk("pend", 32'h0, {31'h0, evp});
        bus(0, 1'b0, REG_DIAG0, 32'h0);
        chk("diag0", 32'h220004dc, q);
        bus(0, 1'b0, REG_STAT, 32'h0);
        chk("stat", 32'h12, q & 32'h1e);
    endtask
    task automatic t_event_v0();
        ovl <= 1'b0;
        pulse(5'h08);
        pulse(5'h02);
        bus(0, 1'b1, REG_CTRL, 32'h0);
        evs <= 8'h05;
        evd <= 32'hddccbbaa;
        pulse(5'h01);
        wait_frame();
        chk("ss1", 32'h08, {24'h0, fr[0]});
        chk("v0hdr", 32'h0506, {16'h0, fr[7], fr[6]});
        chk("pend", 32'h0, {31'h0, evp});
        bus(0, 1'b0, REG_DIAG2, 32'h0);
        chk("diag2", 32'hddccbbaa, q);
        bus(0, 1'b0, REG_DIAG1, 32'h0);
        chk("diag1", {16'h0506, VID}, q);
        bus(0, 1'b0, REG_STAT, 32'h0);
        chk("stat", 32'h02, q & 32'h1e);
        bus(0, 1'b1, REG_CTRL, 32'h2);
        wait_frame();
        chk("v0ss1", 32'h0, {16'h0, fr[7], fr[0]});
        chk("v0sts", 32'h0000beef, {fr[11], fr[10], fr[9], fr[8]});
    endtask
    task automatic t_silent();
        bus(1, 1'b1, REG_CTRL, 32'h3);
        repeat (40) @(posedge clk);
        bus(1, 1'b0, REG_DIAG0, 32'h0);
        chk("tdiag0", 32'h21, q & 32'h21);
        bus(1, 1'b0, REG_STAT, 32'h0);
        chk("tstat", 32'h08, q & 32'h08);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    initial begin
        {srst, pfs, pok, crj, cok, nrdy, ovl, evv} = 8'h80;
        {oad, evs, evd, st_data, idx, nfr, nbusy, miscompares, check_count} = '0;
        for (int s = 0; s < 2; s++) begin
            {av_a[s], av_r[s], av_w[s], av_wd[s]} = '0;
        end
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_status_v1();
        t_event_v1();
        t_event_v0();
        t_silent();
        stop_test();
    end
endmodule
`default_nettype wire
